// ===== ddrh_pkg.sv
package ddrh_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clocking: the memory clock is the system clock divided down
  localparam int CLK_NS = 10;
  localparam int CK_DIV = 4;
  localparam int TCK_NS = CLK_NS * CK_DIV;

  // Nanosecond figure to whole memory clocks, always rounding up
  function automatic int ns_to_ck(input int ns);
    return (ns + TCK_NS - 1) / TCK_NS;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Device timing, each in its own unit
  localparam int WR_NS = 15;
  localparam int RP_NS = 20;
  localparam int RCD_NS = 20;
  localparam int RFC_NS = 75;
  localparam int XSNR_NS = 75;
  localparam real REFI_US = 7.8;
  localparam int MRD_CK = 2;
  localparam int XSRD_CK = 200;
  localparam int INIT_CK = 200;
  localparam int CL_CK = 2;
  localparam int WL_CK = 1;
  localparam int BURST_CK = 1;

  // Derived clock counts
  localparam int WR_CK = ns_to_ck(WR_NS);
  localparam int RP_CK = ns_to_ck(RP_NS);
  localparam int RCD_CK = ns_to_ck(RCD_NS);
  localparam int RFC_CK = ns_to_ck(RFC_NS);
  localparam int DAL_CK = WR_CK + RP_CK;
  // Exit delay is the longer of its own figure and refresh cycle plus one clock
  localparam int XSNR_A = ns_to_ck(XSNR_NS);
  localparam int XSNR_B = RFC_CK + 1;
  localparam int XSNR_CK = (XSNR_A > XSNR_B) ? XSNR_A : XSNR_B;
  // Longest interval rounds down
  localparam int REFI_CK = int'(REFI_US * 1000.0) / TCK_NS;
  localparam int RD_GAP_CK = CL_CK + BURST_CK + RP_CK;
  localparam int WR_GAP_CK = WL_CK + BURST_CK + DAL_CK;
  localparam int RD_WIN_CLK = (CL_CK + BURST_CK + 2) * CK_DIV;

  // Slot gaps as loaded into the gap counter (XSRD_GAP into rd_block), then refresh, read window and debt limits
  localparam logic [7:0] INIT_GAP = 8'(INIT_CK - 1);
  localparam logic [7:0] RP_GAP = 8'(RP_CK - 1);
  localparam logic [7:0] RCD_GAP = 8'(RCD_CK - 1);
  localparam logic [7:0] MRD_GAP = 8'(MRD_CK - 1);
  localparam logic [7:0] RFC_GAP = 8'(RFC_CK - 1);
  localparam logic [7:0] XSNR_GAP = 8'(XSNR_CK - 1);
  localparam logic [7:0] XSRD_GAP = 8'(XSRD_CK - 1);
  localparam logic [7:0] RD_GAP = 8'(RD_GAP_CK - 1);
  localparam logic [7:0] WR_GAP = 8'(WR_GAP_CK - 1);
  localparam logic [7:0] REFI_LAST = 8'(REFI_CK - 1);
  localparam logic [4:0] RD_WIN = 5'(RD_WIN_CLK);
  localparam logic [3:0] REF_MAX = 4'h8;

  // Write strobe steps, in system clocks from the write slot
  localparam logic [3:0] WS_DQ0 = 4'h5;
  localparam logic [3:0] WS_RISE = 4'h6;
  localparam logic [3:0] WS_DQ1 = 4'h7;
  localparam logic [3:0] WS_FALL = 4'h8;
  localparam logic [3:0] WS_LAST = 4'h9;

  ////////////////////////////////////////////////////////////////////////////
  // Command codes {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_MRS = 4'h0;
  // Burst of two, sequential, latency two
  localparam logic [12:0] MODE_WORD = 13'h0021;
  localparam logic [12:0] A10_MASK = 13'h0400;

  typedef enum logic [2:0] {
    OP_READ = 3'b000,
    OP_WRITE = 3'b001,
    OP_MODE = 3'b010,
    OP_SREF_IN = 3'b011,
    OP_SREF_OUT = 3'b100
  } ddrh_op_e;

  typedef enum logic [2:0] {
    ST_PWR = 3'b000,
    ST_PALL = 3'b001,
    ST_MRS = 3'b010,
    ST_IREF = 3'b011,
    ST_IDLE = 3'b100,
    ST_COL = 3'b101,
    ST_SELF = 3'b110
  } ddrh_state_e;

  typedef struct packed {
    ddrh_op_e op;
    logic [1:0] ba;
    logic [12:0] row;
    logic [9:0] col;
    logic [15:0] wdata;
  } ddrh_req_s;

  typedef struct packed {
    logic cke;
    logic [3:0] cmd;
    logic [1:0] ba;
    logic [12:0] addr;
    logic dm;
  } ddrh_pins_s;

endpackage

// ===== ddrh_rdbuf.sv
`timescale 1ns/10ps
module ddrh_rdbuf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready,
  output logic empty
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic push;
  logic pop;

  // Honest flags straight from the count
  assign in_ready = (count != CW'(DEPTH));
  assign out_valid = (count != '0);
  assign empty = (count == '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and occupancy
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + PW'(1);
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + PW'(1);
      end
      count <= count + CW'(push) - CW'(pop);
    end
  end

endmodule // ddrh_rdbuf

// ===== ddrh_ctrl.sv
`timescale 1ns/10ps
module ddrh_ctrl
  import ddrh_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // User requests
  input wire logic req_valid,
  input wire ddrh_req_s req,
  output logic req_ready,
  input wire logic fault,
  // Read data stream
  output logic rd_valid,
  output logic [7:0] rd_data,
  input wire logic rd_ready,
  // Status
  output logic init_done,
  output logic in_self_ref,
  // Memory command pins
  output logic ck_out,
  output ddrh_pins_s pins,
  // Memory data and strobe
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe,
  input wire logic dqs_in,
  output logic dqs_out,
  output logic dqs_oe
);

  logic [1:0] phase;
  logic tick;
  logic gap_ok;
  ddrh_state_e state;
  logic [7:0] gap;
  logic init_ref;
  ddrh_req_s held;
  logic req_ok;
  logic ref_go;
  logic acc;
  logic wr_go;
  logic rd_go;
  logic ref_run;
  logic ref_due;
  logic [7:0] ref_cnt;
  logic [3:0] owed;
  logic [7:0] rd_block;
  logic [3:0] wstep;
  logic [3:0] next_wstep;
  logic dqs_s1;
  logic dqs_s2;
  logic dqs_s3;
  logic [7:0] dq_s1;
  logic [7:0] dq_s2;
  logic [4:0] rd_win;
  logic [1:0] rd_words;
  logic cap_rise;
  logic cap_fall;
  logic buf_in_ready;
  logic buf_empty;

  ////////////////////////////////////////////////////////////////////////////
  // Memory clock: high in phases 0 and 1, commands change in phase 3
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 2'h0;
      ck_out <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      ck_out <= (phase == 2'h3) || (phase == 2'h0);
    end
  end

  // Decisions are taken mid low phase so pins settle before the rise
  assign tick = (phase == 2'h2);
  assign gap_ok = tick && (gap == 8'h00);
  assign init_done = (state == ST_IDLE) || (state == ST_COL) || (state == ST_SELF);
  assign in_self_ref = (state == ST_SELF);

  // Which requests may go now
  always_comb begin
    case (req.op)
      OP_READ: req_ok = (state == ST_IDLE) && buf_empty && buf_in_ready
                        && (rd_block == 8'h00) && (rd_win == 5'h00);
      OP_SREF_OUT: req_ok = 1'b1;
      default: req_ok = (state == ST_IDLE);
    endcase
  end

  // A full refresh debt beats any request
  assign req_ready = gap_ok && req_ok
                     && (((state == ST_IDLE) && (owed != REF_MAX)) || (state == ST_SELF));
  assign ref_go = gap_ok && (state == ST_IDLE) && (owed != 4'h0)
                  && ((owed == REF_MAX) || !req_valid || !req_ok);
  assign acc = req_valid && req_ready;
  assign wr_go = gap_ok && (state == ST_COL) && (held.op == OP_WRITE);
  assign rd_go = gap_ok && (state == ST_COL) && (held.op == OP_READ);

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer; gap counts memory clocks to the next legal slot
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_PWR;
      gap <= INIT_GAP;
      init_ref <= 1'b0;
      held <= '0;
      pins <= '{cke: 1'b0, cmd: CMD_NOP, ba: 2'h0, addr: 13'h0000, dm: 1'b0};
    end else if (fault) begin
      // Unknown device state: start over from power down
      state <= ST_PWR;
      gap <= INIT_GAP;
      pins.cke <= 1'b0;
      pins.cmd <= CMD_NOP;
    end else if (tick) begin
      pins.cmd <= CMD_NOP;
      if (gap != 8'h00) begin
        gap <= gap - 8'h01;
      end else begin
        case (state)
          ST_PWR: begin
            pins.cke <= 1'b1;
            gap <= 8'h01;
            state <= ST_PALL;
          end
          ST_PALL: begin
            pins.cmd <= CMD_PRE;
            pins.addr <= A10_MASK;
            gap <= RP_GAP;
            state <= ST_MRS;
          end
          ST_MRS: begin
            pins.cmd <= CMD_MRS;
            pins.ba <= 2'h0;
            pins.addr <= MODE_WORD;
            gap <= MRD_GAP;
            init_ref <= 1'b0;
            state <= ST_IREF;
          end
          ST_IREF: begin
            pins.cmd <= CMD_REF;
            gap <= RFC_GAP;
            init_ref <= 1'b1;
            if (init_ref) begin
              state <= ST_IDLE;
            end
          end
          ST_IDLE: begin
            if (ref_go) begin
              pins.cmd <= CMD_REF;
              gap <= RFC_GAP;
            end else if (acc) begin
              case (req.op)
                OP_READ, OP_WRITE: begin
                  pins.cmd <= CMD_ACT;
                  pins.ba <= req.ba;
                  pins.addr <= req.row;
                  held <= req;
                  gap <= RCD_GAP;
                  state <= ST_COL;
                end
                OP_MODE: begin
                  pins.cmd <= CMD_MRS;
                  pins.ba <= req.ba;
                  pins.addr <= req.row;
                  gap <= MRD_GAP;
                end
                OP_SREF_IN: begin
                  pins.cmd <= CMD_REF;
                  pins.cke <= 1'b0;
                  state <= ST_SELF;
                end
                default: begin
                  state <= ST_IDLE;
                end
              endcase
            end
          end
          ST_COL: begin
            // Column access always closes the row by auto precharge
            pins.cmd <= (held.op == OP_WRITE) ? CMD_WR : CMD_RD;
            pins.addr <= A10_MASK | {3'h0, held.col};
            gap <= (held.op == OP_WRITE) ? WR_GAP : RD_GAP;
            state <= ST_IDLE;
          end
          ST_SELF: begin
            if (acc) begin
              pins.cke <= 1'b1;
              gap <= XSNR_GAP;
              state <= ST_IDLE;
            end
          end
          default: begin
            state <= ST_PWR;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Refresh debt: one owed per interval, paid when the bus is free
  assign ref_run = (state == ST_IDLE) || (state == ST_COL);
  assign ref_due = (ref_cnt == REFI_LAST);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_cnt <= 8'h00;
      owed <= 4'h0;
    end else if (!ref_run || fault) begin
      // Self refresh and init leave the array fresh
      ref_cnt <= 8'h00;
      owed <= 4'h0;
    end else if (tick) begin
      ref_cnt <= ref_due ? 8'h00 : ref_cnt + 8'h01;
      owed <= owed + {3'h0, ref_due && (owed != REF_MAX)} - {3'h0, ref_go};
    end
  end

  // Reads stay blocked while the delay loop relocks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_block <= 8'h00;
    end else if (fault) begin
      rd_block <= 8'h00;
    end else if (tick && (state == ST_SELF) && acc) begin
      rd_block <= XSRD_GAP;
    end else if (tick && (rd_block != 8'h00)) begin
      rd_block <= rd_block - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write strobe and data, stepped in quarter memory clocks
  always_comb begin
    if (fault) begin
      next_wstep = 4'h0;
    end else if (wr_go) begin
      next_wstep = 4'h1;
    end else if ((wstep == WS_LAST) || (wstep == 4'h0)) begin
      next_wstep = 4'h0;
    end else begin
      next_wstep = wstep + 4'h1;
    end
  end

  // Outputs from flops so strobe edges carry no decode glitches
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wstep <= 4'h0;
      dqs_oe <= 1'b0;
      dqs_out <= 1'b0;
      dq_oe <= 1'b0;
      dq_out <= 8'h00;
    end else begin
      wstep <= next_wstep;
      dqs_oe <= (next_wstep != 4'h0);
      dqs_out <= (next_wstep >= WS_RISE) && (next_wstep < WS_FALL);
      dq_oe <= (next_wstep >= WS_DQ0) && (next_wstep <= WS_FALL);
      dq_out <= (next_wstep < WS_DQ1) ? held.wdata[7:0] : held.wdata[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read capture: strobe and data synchronised alike
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dqs_s1 <= 1'b0;
      dqs_s2 <= 1'b0;
      dqs_s3 <= 1'b0;
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
    end else begin
      dqs_s1 <= dqs_in;
      dqs_s2 <= dqs_s1;
      dqs_s3 <= dqs_s2;
      dq_s1 <= dq_in;
      dq_s2 <= dq_s1;
    end
  end

  // Lead is low, so the first rise marks word 0 and the fall word 1
  assign cap_rise = (rd_win != 5'h00) && (rd_words == 2'h0) && dqs_s2 && !dqs_s3;
  assign cap_fall = (rd_win != 5'h00) && (rd_words == 2'h1) && !dqs_s2 && dqs_s3;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_win <= 5'h00;
      rd_words <= 2'h0;
    end else if (fault) begin
      rd_win <= 5'h00;
      rd_words <= 2'h0;
    end else if (rd_go) begin
      rd_win <= RD_WIN;
      rd_words <= 2'h0;
    end else begin
      if (rd_win != 5'h00) begin
        rd_win <= rd_win - 5'h01;
      end
      if (cap_rise || cap_fall) begin
        rd_words <= rd_words + 2'h1;
      end
    end
  end

  // Reads start only into an empty buffer, so a burst never overflows
  ddrh_rdbuf #(.WIDTH(8), .DEPTH(2)) u_rdbuf (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(cap_rise || cap_fall),
    .in_data(dq_s2),
    .in_ready(buf_in_ready),
    .out_valid(rd_valid),
    .out_data(rd_data),
    .out_ready(rd_ready),
    .empty(buf_empty)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the pins, the refresh debt and the sequencer state
  logic [7:0] xs_cnt;
  logic was_self;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      xs_cnt <= 8'h00;
      was_self <= 1'b0;
    end else begin
      if (!pins.cke) begin
        xs_cnt <= 8'h00;
      end else if ((phase == 2'h3) && (xs_cnt != 8'hFF)) begin
        xs_cnt <= xs_cnt + 8'h01;
      end
      if (state == ST_PWR) begin
        was_self <= 1'b0;
      end else if ((phase == 2'h3) && !pins.cke && (pins.cmd == CMD_REF)) begin
        was_self <= 1'b1;
      end
    end
  end

  mode_gap_a: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == 2'h3) && (pins.cmd == CMD_MRS) |-> ##4 (pins.cmd == CMD_NOP))
    else $error("command too soon after mode program");
  sref_exit_a: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == 2'h3) && was_self && pins.cke && (pins.cmd != CMD_NOP)
    && (pins.cmd != CMD_RD) |-> (xs_cnt >= 8'(XSNR_CK)))
    else $error("command too soon after self refresh exit");
  sref_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == 2'h3) && was_self && (pins.cmd == CMD_RD) |-> (xs_cnt >= 8'(XSRD_CK)))
    else $error("read too soon after self refresh exit");
  ref_force_a: assert property (@(posedge clk) disable iff (!rst_n)
    gap_ok && (state == ST_IDLE) && (owed == REF_MAX) |=> (pins.cmd == CMD_REF) ##3 (owed < REF_MAX))
    else $error("full refresh debt not paid");
  owed_cap_a: assert property (@(posedge clk) disable iff (!rst_n)
    owed <= REF_MAX)
    else $error("more than eight refreshes owed");
  wr_recover_a: assert property (@(posedge clk) disable iff (!rst_n)
    (phase == 2'h3) && (pins.cmd == CMD_WR)
    |-> ##4 (pins.cmd == CMD_NOP) ##4 (pins.cmd == CMD_NOP) ##4 (pins.cmd == CMD_NOP))
    else $error("bank reused before write recovery");
  wr_place_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(dqs_out) |-> ($past(pins.cmd, 4) == CMD_WR) && (phase == 2'h0))
    else $error("first write strobe rise misplaced");
  strobe_width_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(dqs_out) |-> dqs_out ##1 dqs_out ##1 !dqs_out ##1 !dqs_out)
    else $error("write strobe phase too short");
  fall_center_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(dqs_out) |-> (phase == 2'h2) && !ck_out)
    else $error("write strobe fall too near a clock rise");
  lead_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(dqs_oe) |-> (!dqs_out && dqs_oe)[*5])
    else $error("write strobe lead not held low");
  strobe_tail_a: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(dqs_out) |-> (dqs_oe && !dqs_out)[*2] ##1 !dqs_oe)
    else $error("write strobe tail wrong");
  from_hiz_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(dqs_oe) |-> !dqs_out && (pins.cmd == CMD_WR) && !$past(dq_oe))
    else $error("write strobe lead not driven low from release");
  fault_init_a: assert property (@(posedge clk) disable iff (!rst_n)
    fault |=> (state == ST_PWR) && !pins.cke && (wstep == 4'h0) && (gap == INIT_GAP))
    else $error("fault did not restart initialisation");

  write_cov: cover property (@(posedge clk) disable iff (!rst_n) $rose(dqs_out));
  read_cov: cover property (@(posedge clk) disable iff (!rst_n) rd_valid && rd_ready);
  sref_cov: cover property (@(posedge clk) disable iff (!rst_n)
    acc && (state == ST_SELF));
  debt_cov: cover property (@(posedge clk) disable iff (!rst_n) owed == REF_MAX);

endmodule // ddrh_ctrl

// ===== ddrh_dev.sv
`timescale 1ns/10ps
// Memory stand-in: stores write bursts by column, answers reads with a strobe
module ddrh_dev
  import ddrh_pkg::*;
(
  // Command side
  input wire logic ck,
  input wire ddrh_pins_s pins,
  // Write path from the host
  input wire logic [7:0] dq_w,
  input wire logic dqs_w,
  input wire logic dqs_we,
  // Read path toward the host
  output logic [7:0] dq_r,
  output logic dqs_r
);
  logic [15:0] mem [16];
  logic [3:0] wcol;
  logic [3:0] rcol;
  ////////////////////////////////////////////////////////////////////////////
  // Released strobe starts high, never at a level the host could take as a lead
  initial begin
    dq_r = 8'hA5;
    dqs_r = 1'b1;
    for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
  end
  // Commands are taken on the memory clock rise
  always @(posedge ck) begin
    if (pins.cke && pins.cmd == CMD_WR) wcol = pins.addr[3:0];
    if (pins.cke && pins.cmd == CMD_RD) begin
      rcol = pins.addr[3:0];
      fork
        read_burst();
      join_none
    end
  end
  // Write beats land on both strobe edges while the host drives
  always @(posedge dqs_w) if (dqs_we === 1'b1) mem[wcol][7:0] = dq_w;
  always @(negedge dqs_w) if (dqs_we === 1'b1) mem[wcol][15:8] = dq_w;
  ////////////////////////////////////////////////////////////////////////////
  // Lead of one clock, edge-aligned beats, half-clock tail, then inverse levels
  task automatic read_burst();
    // Half a system clock of skew keeps every edge off the host's sampling edge
    #(TCK_NS * (CL_CK - 1) + CLK_NS / 2) dqs_r = 1'b0;
    #(TCK_NS) dqs_r = 1'b1;
    dq_r = mem[rcol][7:0];
    #(TCK_NS / 2) dqs_r = 1'b0;
    dq_r = mem[rcol][15:8];
    #(TCK_NS / 2) dqs_r = 1'b1;
    dq_r = ~dq_r;
  endtask
endmodule // ddrh_dev

// ===== ddrh_ctrl_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin failures++; \
  $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end
module ddrh_ctrl_tb;
  import ddrh_pkg::*;
  localparam int DAL_EXP = (WR_NS + TCK_NS - 1) / TCK_NS + (RP_NS + TCK_NS - 1) / TCK_NS;
  logic clk, rst_n, req_valid, req_ready, fault, rd_valid, rd_ready, init_done, in_self_ref;
  logic ck_out, dq_oe, dqs_in, dqs_out, dqs_oe, dev_dqs;
  logic [7:0] rd_data, dq_in, dq_out, dev_dq;
  ddrh_req_s req;
  ddrh_pins_s pins;
  int failures, samples_checked, ckn, t_mrs, t_wr, t_exit, refs, mrss;
  logic mrs_pend, wr_pend, xs_pend, xr_pend, cke_q, wr_first;
  real t_ck, t_wrcmd, t_rise, t_fall;
  // Shared strobe and data wires: whoever enables drives
  assign dqs_in = dqs_oe ? dqs_out : dev_dqs;
  assign dq_in = dq_oe ? dq_out : dev_dq;
  ddrh_ctrl dut (.clk(clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .fault(fault), .rd_valid(rd_valid), .rd_data(rd_data),
    .rd_ready(rd_ready), .init_done(init_done), .in_self_ref(in_self_ref), .ck_out(ck_out),
    .pins(pins), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_in(dqs_in),
    .dqs_out(dqs_out), .dqs_oe(dqs_oe));
  ddrh_dev mem (.ck(ck_out), .pins(pins), .dq_w(dq_out), .dqs_w(dqs_out), .dqs_we(dqs_oe),
    .dq_r(dev_dq), .dqs_r(dev_dqs));
  ////////////////////////////////////////////////////////////////////////////
  // Command monitor at the memory clock rise, where the memory samples
  always @(posedge ck_out) begin
    ckn++;
    t_ck = $realtime;
    if (pins.cke && !cke_q && init_done === 1'b1) begin
      t_exit = ckn;
      xs_pend = 1'b1;
      xr_pend = 1'b1;
    end
    if (pins.cke && pins.cmd != CMD_NOP) begin
      if (mrs_pend) `CHK(ckn - t_mrs >= 2, 1'b1)
      if (pins.cmd == CMD_ACT && wr_pend) `CHK(ckn - t_wr >= WL_CK + BURST_CK + DAL_EXP, 1'b1)
      if (pins.cmd == CMD_RD && xr_pend) `CHK(ckn - t_exit >= 200, 1'b1)
      if (pins.cmd != CMD_RD && xs_pend) `CHK((ckn - t_exit) * TCK_NS >= 75, 1'b1)
      if (pins.cmd == CMD_RD) xr_pend = 1'b0;
      if (pins.cmd != CMD_RD) xs_pend = 1'b0;
      if (pins.cmd == CMD_REF) refs++;
      if (pins.cmd == CMD_MRS) mrss++;
      mrs_pend = (pins.cmd == CMD_MRS);
      t_mrs = ckn;
      if (pins.cmd == CMD_ACT) wr_pend = 1'b0;
      if (pins.cmd == CMD_WR) begin
        wr_pend = 1'b1;
        t_wr = ckn;
        t_wrcmd = $realtime;
        wr_first = 1'b1;
        `CHK({dqs_oe, dqs_out}, 2'b10)
      end
    end
    cke_q = pins.cke;
  end
  // Write strobe shape, measured against the memory clock
  always @(posedge dqs_out) if (dqs_oe === 1'b1) begin
    t_rise = $realtime;
    if (wr_first) `CHK(t_rise - t_wrcmd >= 0.72 * TCK_NS && t_rise - t_wrcmd <= 1.25 * TCK_NS, 1'b1)
    wr_first = 1'b0;
    `CHK(t_rise - t_fall >= 0.35 * TCK_NS, 1'b1)
  end
  always @(negedge dqs_out) if (dqs_oe === 1'b1) begin
    t_fall = $realtime;
    `CHK(t_fall - t_rise >= 0.35 * TCK_NS, 1'b1)
    `CHK(t_fall - t_ck >= 0.2 * TCK_NS && t_ck + TCK_NS - t_fall >= 0.2 * TCK_NS, 1'b1)
  end
  always @(negedge dqs_oe) if (t_fall > 0) `CHK($realtime - t_fall >= 0.4 * TCK_NS, 1'b1)
  ////////////////////////////////////////////////////////////////////////////
  // Ready is sampled off-edge; it only moves on rising edges
  task automatic do_req(input ddrh_op_e op, input logic [9:0] col, input logic [15:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{op: op, ba: 2'h1, row: MODE_WORD, col: col, wdata: wd};
    do begin
      @(negedge clk);
      n++;
    end while (n < 30000 && req_ready !== 1'b1);
    @(posedge clk);
    req_valid <= 1'b0;
  endtask
  // Take one buffered word and compare it
  task automatic pop(input logic [7:0] exp);
    int n;
    for (n = 0; n < 500; n++) begin
      @(negedge clk);
      if (rd_valid === 1'b1) break;
    end
    `CHK(rd_valid, 1'b1)
    `CHK(rd_data, exp)
    @(posedge clk);
    rd_ready <= 1'b1;
    @(posedge clk);
    rd_ready <= 1'b0;
  endtask
  task automatic t_wr_rd();
    do_req(OP_MODE, 10'h000, 16'h0000);
    do_req(OP_WRITE, 10'h003, 16'hC35A);
    do_req(OP_WRITE, 10'h004, 16'h0FF0);
    do_req(OP_READ, 10'h003, 16'h0000);
    // Stall long enough for both beats to pile up in the buffer
    repeat (200) @(posedge clk);
    `CHK({rd_valid, rd_data}, 9'h15A)
    pop(8'h5A);
    pop(8'hC3);
    @(negedge clk);
    `CHK(rd_valid, 1'b0)
    $display("test write_read done");
  endtask
  task automatic t_sref();
    do_req(OP_SREF_IN, 10'h000, 16'h0000);
    repeat (400) @(posedge clk);
    `CHK({in_self_ref, pins.cke}, 2'b10)
    do_req(OP_SREF_OUT, 10'h000, 16'h0000);
    do_req(OP_READ, 10'h004, 16'h0000);
    pop(8'hF0);
    pop(8'h0F);
    $display("test self_refresh done");
  endtask
  task automatic t_refresh();
    int r0;
    r0 = refs;
    repeat (600 * CK_DIV) @(posedge clk);
    `CHK(refs - r0 >= 600 * TCK_NS / 7800 - 1, 1'b1)
    $display("test refresh done");
  endtask
  task automatic t_fault();
    int m0;
    int n;
    m0 = mrss;
    @(posedge clk);
    fault <= 1'b1;
    @(posedge clk);
    fault <= 1'b0;
    repeat (2) @(negedge clk);
    `CHK({init_done, pins.cke}, 2'b00)
    for (n = 0; n < 20000 && init_done !== 1'b1; n++) @(negedge clk);
    `CHK(mrss - m0, 1)
    $display("test fault done");
  endtask
  task automatic test_done();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Guard against a hang; all tests need well under this span
  initial begin
    #500000;
    failures++;
    test_done();
  end
  initial begin
    rst_n = 1'b0;
    fault = 1'b0;
    req_valid = 1'b0;
    req = '0;
    rd_ready = 1'b0;
    repeat (20) @(posedge clk);
    `CHK({pins.cke, pins.cmd, dqs_oe, dq_oe, rd_valid}, {1'b0, CMD_NOP, 3'b000})
    rst_n <= 1'b1;
    for (int n = 0; n < 20000 && init_done !== 1'b1; n++) @(negedge clk);
    // The second init refresh reaches the memory one system clock later
    repeat (4) @(negedge clk);
    `CHK(refs, 2)
    t_wr_rd();
    t_sref();
    t_refresh();
    t_fault();
    test_done();
  end
endmodule // ddrh_ctrl_tb
